// >>> sram_port_device.sv
// Device end: two-word burst SRAM with separate read and write ports
//
// What this block does
// - Write starts on load low, select low
// - Read words on negative t+1, positive t+2
// - Burst words use offsets zero then one
// - After power-up deselected, outputs high Z
// - Sample on input rises, drive on outputs
// - 18-bit: two lanes of nine bits
// - 36-bit: four lanes of nine bits
// - All lanes high leaves word unchanged
// - Lanes evaluated separately for each beat
// - Controller should park clocks when stopping
// - Pll off pin low cuts latency to one
// - Single clock mode strapped at power on
// - Last write's second word held, committed on next write
module sram_port_device #(
  parameter int ADDR_W = sram_port_pkg::ADDR_W_DEF,
  parameter int DATA_W = sram_port_pkg::DATA_W_DEF
) (
  input wire logic   clock,             // System clock
  input wire logic   rst,               // Asynchronous reset
  sram_link_if.mem   link,              // Pins facing the controller
  output logic       single_clock_mode, // Strapped clocking mode
  output logic       posted_pending     // A write word awaits commit
);
  import sram_port_pkg::*;

  // ---------------------------------------------------------------
  // Sizes and checks
  // ---------------------------------------------------------------
  localparam int LANES = DATA_W / LANE_W;
  localparam int WA_W  = ADDR_W + 1;       // Word address width
  localparam int DEPTH = 2 ** WA_W;

  initial begin
    if (DATA_W != 18 && DATA_W != 36) begin
      $error("Word width must be 18 or 36");
    end
    if (ADDR_W < 1 || ADDR_W > 24) begin
      $error("Address width out of range");
    end
  end

  // Merge a beat into a stored word under active-low lane selects
  function automatic logic [DATA_W-1:0] merge(
    input logic [DATA_W-1:0] old_word,
    input logic [DATA_W-1:0] new_word,
    input logic [LANES-1:0]  lane_n
  );
    logic [DATA_W-1:0] res;
    res = old_word;
    for (int i = 0; i < LANES; i++) begin
      if (!lane_n[i]) begin
        res[i*LANE_W +: LANE_W] = new_word[i*LANE_W +: LANE_W];
      end
    end
    return res;
  endfunction : merge

  // ---------------------------------------------------------------
  // Storage and state
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] mem_q [DEPTH];       // Memory array
  logic              strap_taken_q;       // Strap already caught
  logic              single_q;            // Single clock mode
  logic [RD_DEPTH-1:0] rd_v_q;            // Read pipeline valids
  logic [ADDR_W-1:0] rd_a_q [RD_DEPTH];   // Read pipeline addresses
  logic [WR_DEPTH-1:0] wr_v_q;            // Write pipeline valids
  logic [ADDR_W-1:0] wr_a_q [WR_DEPTH];   // Write pipeline addresses
  logic              post_v_q;            // Posted word is held
  logic [WA_W-1:0]   post_a_q;            // Posted word address
  logic [DATA_W-1:0] post_d_q;            // Posted word data
  logic [LANES-1:0]  post_l_q;            // Posted word lane selects
  logic [DATA_W-1:0] rdata_q;             // Read output register
  logic              oe_q;                // Read output enable

  // ---------------------------------------------------------------
  // Edge qualifiers
  // ---------------------------------------------------------------
  logic k_edge;    // An input clock rise happens this cycle
  logic out_edge;  // An output clock rise happens this cycle
  logic cmd;       // Access launched on this positive rise
  logic beat0;     // First write beat sampled now
  logic beat1;     // Second write beat sampled now
  int   rd_i0;     // Pipeline stage of the first read word

  assign k_edge   = link.k_run;
  // Outputs follow the input pair in single clock mode
  assign out_edge = single_q ? link.k_run : link.c_run;
  // Load high: select is ignored and nothing starts
  assign cmd      = k_edge && link.k_phase == PHASE_POS &&
                    !link.address_load_n;
  assign beat0    = k_edge && wr_v_q[WR_IDX_BEAT0] &&
                    link.k_phase == PHASE_POS;
  assign beat1    = k_edge && wr_v_q[WR_IDX_BEAT0+1] &&
                    link.k_phase == PHASE_NEG;
  assign rd_i0    = link.pll_off_pin ? RD_IDX_PLL_ON
                                     : RD_IDX_PLL_OFF;

  // ---------------------------------------------------------------
  // Strap capture
  // ---------------------------------------------------------------
  // Caught once on the first edge after reset, never again
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strap_taken_q <= 1'b0;
      single_q      <= 1'b0;
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'b1;
      single_q      <= link.c_pair_high;
    end
  end

  // ---------------------------------------------------------------
  // Command pipelines
  // ---------------------------------------------------------------
  // Shift one stage per input rise; a stopped clock freezes them
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_v_q <= '0;
      wr_v_q <= '0;
    end else if (k_edge) begin
      rd_v_q <= {rd_v_q[RD_DEPTH-2:0], cmd && link.rw_sel};
      wr_v_q <= {wr_v_q[WR_DEPTH-2:0], cmd && !link.rw_sel};
    end
  end

  // Addresses need no reset; their valids guard them
  always_ff @(posedge clock) begin
    if (k_edge) begin
      rd_a_q[0] <= link.addr;
      wr_a_q[0] <= link.addr;
      for (int i = 1; i < RD_DEPTH; i++) begin
        rd_a_q[i] <= rd_a_q[i-1];
      end
      for (int i = 1; i < WR_DEPTH; i++) begin
        wr_a_q[i] <= wr_a_q[i-1];
      end
    end
  end

  // ---------------------------------------------------------------
  // Array write port
  // ---------------------------------------------------------------
  // One array write per cycle: the first beat goes straight in, and
  // the second beat retires the previously posted word; the posted
  // word is always odd and a first beat always even, so no clash
  logic [WA_W-1:0] b0_addr;   // Word address of the first beat

  assign b0_addr = {wr_a_q[WR_IDX_BEAT0], 1'b0};

  always_ff @(posedge clock) begin
    if (beat0) begin
      mem_q[b0_addr] <= merge(mem_q[b0_addr], link.wdata,
                              link.byte_lane_sel_n);
    end else if (beat1 && post_v_q) begin
      mem_q[post_a_q] <= merge(mem_q[post_a_q], post_d_q,
                               post_l_q);
    end
  end

  // ---------------------------------------------------------------
  // Posted write register
  // ---------------------------------------------------------------
  // Keeping the last word aside avoids a clash with a read that
  // follows; it retires on the next write's second beat
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      post_v_q <= 1'b0;
      post_a_q <= '0;
      post_d_q <= '0;
      post_l_q <= '1;
    end else if (beat1) begin
      post_v_q <= 1'b1;
      post_a_q <= {wr_a_q[WR_IDX_BEAT0+1], 1'b1};
      post_d_q <= link.wdata;
      post_l_q <= link.byte_lane_sel_n;
    end
  end

  // Array view with the posted word folded in
  function automatic logic [DATA_W-1:0] fetch(
    input logic [WA_W-1:0] a
  );
    logic [DATA_W-1:0] w;
    w = mem_q[a];
    if (post_v_q && post_a_q == a) begin
      w = merge(w, post_d_q, post_l_q);
    end
    return w;
  endfunction : fetch

  // ---------------------------------------------------------------
  // Read output register
  // ---------------------------------------------------------------
  // Outputs move only on output rises, so a stopped clock holds
  // them; with no word due they float once the burst is done
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_q <= '0;
      oe_q    <= 1'b0;
    end else if (out_edge) begin
      if (rd_v_q[rd_i0]) begin
        rdata_q <= fetch({rd_a_q[rd_i0], 1'b0});
        oe_q    <= 1'b1;
      end else if (rd_v_q[rd_i0+1]) begin
        rdata_q <= fetch({rd_a_q[rd_i0+1], 1'b1});
        oe_q    <= 1'b1;
      end else begin
        oe_q    <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign link.rdata        = rdata_q;
  assign link.rdata_oe     = oe_q;
  assign single_clock_mode = single_q;
  assign posted_pending    = post_v_q;
endmodule : sram_port_device

// >>> sram_port_pkg.sv
// Shared constants and types for the burst SRAM port and its controller
package sram_port_pkg;
  // ---------------------------------------------------------------
  // Organisation
  // ---------------------------------------------------------------
  localparam int LANE_W     = 9;   // Bits covered by one lane select
  localparam int ADDR_W_DEF = 20;  // Burst-pair address width
  localparam int DATA_W_DEF = 18;  // Word width, 18 or 36
  // ---------------------------------------------------------------
  // Half-cycle phases of the input clock pair
  // ---------------------------------------------------------------
  localparam logic PHASE_POS = 1'b0; // Half ending on a positive rise
  localparam logic PHASE_NEG = 1'b1; // Half ending on a negative rise
  // ---------------------------------------------------------------
  // Pipeline positions, in half-cycles after the command edge
  // ---------------------------------------------------------------
  localparam int RD_IDX_PLL_ON  = 2; // First read word, 1.5 cycles
  localparam int RD_IDX_PLL_OFF = 1; // First read word, 1 cycle
  localparam int WR_IDX_BEAT0   = 1; // First write beat, next positive rise
  localparam int RD_DEPTH       = 4; // Read tracking stages
  localparam int WR_DEPTH       = 3; // Write tracking stages
  // ---------------------------------------------------------------
  // Controller clock states
  // ---------------------------------------------------------------
  typedef enum logic {clk_running, clk_halted} clk_state_type;
endpackage : sram_port_pkg

// >>> sram_link_if.sv
// Pin-level link between a memory controller and the burst SRAM port
interface sram_link_if #(
  parameter int ADDR_W = sram_port_pkg::ADDR_W_DEF,
  parameter int DATA_W = sram_port_pkg::DATA_W_DEF
);
  localparam int LANES = DATA_W / sram_port_pkg::LANE_W;
  logic              k_run;           // Input clock pair is toggling
  logic              k_phase;         // Which input rise ends this half
  logic              c_run;           // Output clock pair is toggling
  logic              c_pair_high;     // Output clocks tied high (strap)
  logic              pll_off_pin;     // Low selects the low-latency legacy mode
  logic              address_load_n;  // Access strobe, active low
  logic              rw_sel;          // High read, low write
  logic [ADDR_W-1:0] addr;            // Burst-pair address
  logic [DATA_W-1:0] wdata;           // Write data beat
  logic [LANES-1:0]  byte_lane_sel_n; // Lane enables, active low
  logic [DATA_W-1:0] rdata;           // Read data word
  logic              rdata_oe;        // Read data driven, else high Z

  modport ctrl (
    output k_run, k_phase, c_run, c_pair_high, pll_off_pin,
    output address_load_n, rw_sel, addr, wdata, byte_lane_sel_n,
    input  rdata, rdata_oe
  );
  modport mem (
    input  k_run, k_phase, c_run, c_pair_high, pll_off_pin,
    input  address_load_n, rw_sel, addr, wdata, byte_lane_sel_n,
    output rdata, rdata_oe
  );
endinterface : sram_link_if

// >>> sram_port_ctrl.sv
// Controller end: launches bursts and drives the SRAM port pins
module sram_port_ctrl #(
  parameter int ADDR_W = sram_port_pkg::ADDR_W_DEF,
  parameter int DATA_W = sram_port_pkg::DATA_W_DEF
) (
  input  wire logic              clock,       // System clock
  input  wire logic              rst,         // Asynchronous reset
  sram_link_if.ctrl              link,        // Pins facing the SRAM
  input  wire logic              req_valid,   // Burst request
  output logic                   req_ready,   // Request taken this cycle
  input  wire logic              req_write,   // High write, low read
  input  wire logic [ADDR_W-1:0] req_addr,    // Burst-pair address
  input  wire logic [DATA_W-1:0] req_wdata0,  // Write word offset zero
  input  wire logic [DATA_W-1:0] req_wdata1,  // Write word offset one
  // Lanes of the first and second write beats, active low
  input  wire logic [DATA_W/sram_port_pkg::LANE_W-1:0] req_lane0_n,
  input  wire logic [DATA_W/sram_port_pkg::LANE_W-1:0] req_lane1_n,
  output logic                   rsp_valid,   // Read burst returned
  output logic      [DATA_W-1:0] rsp_data0,   // Read word offset zero
  output logic      [DATA_W-1:0] rsp_data1,   // Read word offset one
  input  wire logic              stop_req,    // Ask to stop the clocks
  output logic                   stopped,     // Clocks are stopped
  input  wire logic              pll_off_cfg, // Drives the pll off pin
  input  wire logic              single_cfg   // Strap single clock mode
);
  import sram_port_pkg::*;

  localparam int LANES = DATA_W / LANE_W;

  initial begin
    if (DATA_W != 18 && DATA_W != 36) begin
      $error("Word width must be 18 or 36");
    end
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  clk_state_type     state_q;      // Clocks running or halted
  logic              phase_q;      // Phase of the current half
  logic              wpend_q;      // Write issued, data still owed
  logic              w1pend_q;     // Second beat owed
  logic [DATA_W-1:0] wbuf0_q;      // First beat awaiting its slot
  logic [DATA_W-1:0] wbuf1_q;      // Second beat of issued write
  logic [LANES-1:0]  lbuf0_q;      // First beat lanes
  logic [LANES-1:0]  lbuf1_q;      // Second beat lanes
  logic [DATA_W-1:0] w1_q;         // Second beat in flight
  logic [LANES-1:0]  l1_q;         // Second beat lanes in flight
  logic              word_odd_q;   // Next read word is offset one
  logic              issue;        // Burst launched at this edge
  logic              busy;         // Write data owed, strobe out or read word driven

  // Requests only fill the half that ends on a positive rise
  assign req_ready = state_q == clk_running && phase_q == PHASE_NEG;
  assign issue     = req_ready && req_valid;
  assign busy      = wpend_q || w1pend_q || link.rdata_oe ||
                     !link.address_load_n;

  // ---------------------------------------------------------------
  // Clock generation and standby
  // ---------------------------------------------------------------
  // Stops between bursts, or with a read taken but no word yet driven, on a negative half, so the
  // clocks park with both input clocks equal
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= clk_running;
      phase_q <= PHASE_POS;
    end else begin
      case (state_q)
        clk_running: begin
          phase_q <= ~phase_q;
          if (stop_req && !busy && !req_valid &&
              phase_q == PHASE_POS) begin
            state_q <= clk_halted;
          end
        end
        clk_halted: begin
          if (!stop_req) begin
            state_q <= clk_running;
          end
        end
        default: state_q <= clk_running;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Command pins
  // ---------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      link.address_load_n <= 1'b1;
      link.rw_sel         <= 1'b0;
      link.addr           <= '0;
    end else if (state_q == clk_running) begin
      if (phase_q == PHASE_NEG) begin
        link.address_load_n <= !issue;
        link.rw_sel         <= !req_write;
        link.addr           <= req_addr;
      end else begin
        link.address_load_n <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Write data pins
  // ---------------------------------------------------------------
  // First beat goes out a full cycle after its command, second on
  // the next half; lanes may differ between the beats
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wpend_q              <= 1'b0;
      w1pend_q             <= 1'b0;
      wbuf0_q              <= '0;
      wbuf1_q              <= '0;
      lbuf0_q              <= '1;
      lbuf1_q              <= '1;
      w1_q                 <= '0;
      l1_q                 <= '1;
      link.wdata           <= '0;
      link.byte_lane_sel_n <= '1;
    end else if (state_q == clk_running) begin
      if (phase_q == PHASE_NEG) begin
        w1pend_q <= wpend_q;
        if (wpend_q) begin
          link.wdata           <= wbuf0_q;
          link.byte_lane_sel_n <= lbuf0_q;
          w1_q                 <= wbuf1_q;
          l1_q                 <= lbuf1_q;
        end
        wpend_q <= issue && req_write;
        if (issue && req_write) begin
          wbuf0_q <= req_wdata0;
          wbuf1_q <= req_wdata1;
          lbuf0_q <= req_lane0_n;
          lbuf1_q <= req_lane1_n;
        end
      end else if (w1pend_q) begin
        link.wdata           <= w1_q;
        link.byte_lane_sel_n <= l1_q;
        w1pend_q             <= 1'b0;
      end else begin
        link.byte_lane_sel_n <= '1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read capture
  // ---------------------------------------------------------------
  // Words pair up in arrival order; the second completes the burst
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      word_odd_q <= 1'b0;
      rsp_valid  <= 1'b0;
      rsp_data0  <= '0;
      rsp_data1  <= '0;
    end else begin
      rsp_valid <= 1'b0;
      if (link.rdata_oe && state_q == clk_running) begin
        word_odd_q <= ~word_odd_q;
        if (word_odd_q) begin
          rsp_data1 <= link.rdata;
          rsp_valid <= 1'b1;
        end else begin
          rsp_data0 <= link.rdata;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Clock and strap pins
  // ---------------------------------------------------------------
  assign link.k_run       = state_q == clk_running;
  assign link.k_phase     = phase_q;
  assign link.c_run       = !single_cfg && state_q == clk_running;
  assign link.c_pair_high = single_cfg;
  assign link.pll_off_pin = pll_off_cfg;
  assign stopped          = state_q == clk_halted;
endmodule : sram_port_ctrl

// >>> sram_link_asserts.sv
// Concurrent checks on the pins between controller and SRAM port
module sram_link_asserts #(
  parameter int DATA_W = 18
) (
  input wire logic              clock,
  input wire logic              rst,
  input wire logic              k_run,
  input wire logic              k_phase,
  input wire logic              c_run,
  input wire logic              c_pair_high,
  input wire logic              pll_off_pin,
  input wire logic              address_load_n,
  input wire logic              rw_sel,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic              rdata_oe
);
  // ---------------------------------------------------------------
  // Helper logic
  // ---------------------------------------------------------------
  logic rd_cmd;    // Read taken at this edge
  logic seen_rd_q; // A read was launched since reset
  assign rd_cmd = k_run & ~k_phase & ~address_load_n & rw_sel;
  // Outputs must float until the first read, so remember one
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      seen_rd_q <= 1'b0;
    end else if (rd_cmd) begin
      seen_rd_q <= 1'b1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  sequence read_taken; rd_cmd; endsequence
  // Eight running cycles with no strobe: every burst has drained
  sequence quiet_run; (k_run && address_load_n) [*8]; endsequence
  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  strobe_pos_half_a: assert property (
    !address_load_n && k_run |-> !k_phase)
    else $error("strobe on a negative half");
  strobe_one_half_a: assert property (
    !address_load_n |=> address_load_n)
    else $error("strobe longer than one half");
  read_latency_a: assert property (
    read_taken and pll_off_pin |-> ##[3:4] rdata_oe)
    else $error("read word late");
  short_latency_a: assert property (
    read_taken and !pll_off_pin |-> ##[2:3] rdata_oe)
    else $error("legacy read word late");
  oe_cause_a: assert property (
    $rose(rdata_oe) |-> $past(rd_cmd, 3) || $past(rd_cmd, 4))
    else $error("output driven without a read");
  idle_float_a: assert property (
    quiet_run |-> !rdata_oe)
    else $error("outputs driven while idle");
  stop_hold_a: assert property (
    !k_run && !$past(k_run) |-> $stable(rdata) && $stable(rdata_oe))
    else $error("outputs moved while stopped");
  stop_no_access_a: assert property (
    !k_run |-> address_load_n)
    else $error("access while stopped");
  powerup_float_a: assert property (
    !seen_rd_q |-> !rdata_oe)
    else $error("outputs driven before any read");
  single_mode_a: assert property (
    c_pair_high |-> !c_run)
    else $error("output clocks run in single mode");
endmodule : sram_link_asserts

// >>> ddr_sio_burst_sram_port_tb.sv
// Testbench: controller and SRAM port joined, driven from the user side
module ddr_sio_burst_sram_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AW = 20;
  localparam int DW = 18;
  logic          clock = 1'b0;  // 100 MHz system clock
  logic          rst = 1'b1;    // Asynchronous reset
  logic          req_valid, req_ready, req_write, rsp_valid;
  logic [AW-1:0] req_addr;
  logic [DW-1:0] req_wdata0, req_wdata1, rsp_data0, rsp_data1;
  logic [1:0]    req_lane0_n, req_lane1_n;
  logic          stop_req, stopped, pll_off_cfg, single_cfg;
  logic          single_clock_mode, posted_pending;
  logic [DW-1:0] model [logic [AW:0]]; // Expected array contents
  int            mismatches = 0;
  int            num_checks = 0;
  always #5 clock = ~clock;
  sram_link_if #(.ADDR_W(AW), .DATA_W(DW)) sram_link_if_inst ();
  sram_port_ctrl #(.ADDR_W(AW), .DATA_W(DW)) sram_port_ctrl_inst (
    .clock(clock), .rst(rst), .link(sram_link_if_inst),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_wdata0(req_wdata0), .req_wdata1(req_wdata1),
    .req_lane0_n(req_lane0_n), .req_lane1_n(req_lane1_n),
    .rsp_valid(rsp_valid), .rsp_data0(rsp_data0), .rsp_data1(rsp_data1),
    .stop_req(stop_req), .stopped(stopped), .pll_off_cfg(pll_off_cfg),
    .single_cfg(single_cfg));
  sram_port_device #(.ADDR_W(AW), .DATA_W(DW)) sram_port_device_inst (
    .clock(clock), .rst(rst), .link(sram_link_if_inst),
    .single_clock_mode(single_clock_mode), .posted_pending(posted_pending));
  sram_link_asserts #(.DATA_W(DW)) sram_link_asserts_inst (
    .clock(clock), .rst(rst), .k_run(sram_link_if_inst.k_run),
    .k_phase(sram_link_if_inst.k_phase), .c_run(sram_link_if_inst.c_run),
    .c_pair_high(sram_link_if_inst.c_pair_high),
    .pll_off_pin(sram_link_if_inst.pll_off_pin),
    .address_load_n(sram_link_if_inst.address_load_n),
    .rw_sel(sram_link_if_inst.rw_sel), .rdata(sram_link_if_inst.rdata),
    .rdata_oe(sram_link_if_inst.rdata_oe));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [DW-1:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // Enabled lanes take the new bits, the rest keep the old ones
  function automatic logic [DW-1:0] merge(logic [DW-1:0] o, n, logic [1:0] l);
    for (int j = 0; j < 2; j++) if (!l[j]) o[j*9+:9] = n[j*9+:9];
    return o;
  endfunction : merge
  // Holds the request until a cycle with ready high has been taken
  task automatic send(input logic wr, input logic [AW-1:0] a);
    int i;
    @(posedge clock);
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr <= a;
    for (i = 0; i < 40; i++) begin
      @(negedge clock);
      if (req_ready === 1'b1) break;
    end
    if (i == 40) begin mismatches++; tally_and_finish(); end
    @(posedge clock);
    req_valid <= 1'b0;
  endtask : send
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d0, d1,
                    input logic [1:0] l0, l1);
    @(posedge clock);
    req_wdata0 <= d0;
    req_wdata1 <= d1;
    req_lane0_n <= l0;
    req_lane1_n <= l1;
    model[{a, 1'b0}] = merge(model[{a, 1'b0}], d0, l0);
    model[{a, 1'b1}] = merge(model[{a, 1'b1}], d1, l1);
    send(1'b1, a);
  endtask : wr
  // Read burst; responses are a one-cycle pulse, so wait bounded
  task automatic rd(input logic [AW-1:0] a);
    int i;
    send(1'b0, a);
    for (i = 0; i < 30; i++) begin
      @(negedge clock);
      if (rsp_valid === 1'b1) break;
    end
    if (i == 30) begin mismatches++; tally_and_finish(); end
    check("word0", rsp_data0, model[{a, 1'b0}]);
    check("word1", rsp_data1, model[{a, 1'b1}]);
  endtask : rd
  task automatic wait_stop(input logic want);
    int i;
    for (i = 0; i < 40 && stopped !== want; i++) @(negedge clock);
    if (i == 40) begin mismatches++; tally_and_finish(); end
  endtask : wait_stop
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {req_valid, req_write, stop_req, single_cfg} = 4'h0;
    {req_addr, req_wdata0, req_wdata1} = '0;
    {req_lane0_n, req_lane1_n} = 4'hf;
    pll_off_cfg = 1'b1;
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    check("oe", DW'(sram_link_if_inst.rdata_oe), '0);
    wr(20'h00005, 18'h12345, 18'h2abcd, 2'h0, 2'h0);
    rd(20'h00005);
    check("posted", DW'(posted_pending), 18'h00001);
    wr(20'h00003, 18'h3ffff, 18'h3ffff, 2'h0, 2'h0);
    wr(20'h00003, 18'h00000, 18'h00000, 2'h2, 2'h1);
    wr(20'h00003, 18'h15555, 18'h0aaaa, 2'h3, 2'h3);
    wr(20'hfffff, 18'h00f0f, 18'h3c3c3, 2'h0, 2'h0);
    rd(20'h00003);
    rd(20'hfffff);
    rd(20'h00005);
    @(posedge clock);
    pll_off_cfg <= 1'b0;
    rd(20'h00003);
    @(posedge clock);
    pll_off_cfg <= 1'b1;
    stop_req <= 1'b1;
    wait_stop(1'b1);
    repeat (4) @(negedge clock);
    check("k_run", DW'(sram_link_if_inst.k_run), '0);
    @(posedge clock);
    stop_req <= 1'b0;
    wait_stop(1'b0);
    rd(20'h00005);
    @(posedge clock);
    single_cfg <= 1'b1;
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(negedge clock);
    check("single", DW'(single_clock_mode), 18'h00001);
    check("oe", DW'(sram_link_if_inst.rdata_oe), '0);
    wr(20'h00007, 18'h0f0f0, 18'h30303, 2'h0, 2'h0);
    rd(20'h00007);
    tally_and_finish();
  end
endmodule : ddr_sio_burst_sram_port_tb
